/* core/reset_power_control.sv */
// Reset sequencing, supply monitor control and idle/stop mode control,
// with its registers on APB. Assumes presetn is the power-on reset, the
// supply monitor and regulator levels arrive asynchronously, and the core
// signals on the same clock.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module reset_power_control #(
    parameter int unsigned POR_DELAY_NS = rpm_pkg::POR_DELAY_NS,
    parameter int unsigned HOLD_CYCLES  = rpm_pkg::HOLD_CYCLES
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire rpm_pkg::apb_req_type apb_req,
    output rpm_pkg::apb_rsp_type      apb_rsp,
    input  wire logic                 supply_above_pin,
    input  wire logic                 regulator_low_pin,
    input  wire logic                 flash_write_attempt,
    input  wire logic                 irq_pending,
    input  wire logic                 instr_done,
    output logic                      reset_pin_o,
    output logic                      reset_pin_oe,
    output logic                      core_reset,
    output logic                      port_latch_force,
    output logic [7:0]                port_latch_value,
    output logic                      weak_pullup_en,
    output logic                      cpu_clk_en,
    output logic                      osc_enable,
    output logic                      clock_internal_sel,
    output logic                      watchdog_enable,
    output logic [3:0]                watchdog_div,
    output logic                      fetch_start,
    output logic [15:0]               fetch_address
);

    localparam int unsigned CNT_W = rpm_pkg::CNT_W;
    // Least time, rounded up to whole cycles
    localparam int unsigned POR_CYC_RAW =
        (POR_DELAY_NS * 1000 + rpm_pkg::CLK_PERIOD_PS - 1)
        / rpm_pkg::CLK_PERIOD_PS;
    localparam int unsigned POR_CYCLES = (POR_CYC_RAW < 1) ? 1 : POR_CYC_RAW;
    localparam int unsigned HOLD_CYC   = (HOLD_CYCLES < 1) ? 1 : HOLD_CYCLES;
    localparam logic [CNT_W-1:0] POR_LOAD  = CNT_W'(POR_CYCLES - 1);
    localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(HOLD_CYC - 1);

    initial begin
        if (POR_CYCLES > 4096 || HOLD_CYC >= (1 << CNT_W)) begin
            $error("reset_power_control: delay count out of range");
        end
    end

    typedef enum logic [2:0] {
        S_POR_WAIT,
        S_POR_DELAY,
        S_RUN,
        S_IDLE,
        S_STOP,
        S_MON_HOLD,
        S_SOFT_HOLD,
        S_STUCK
    } mode_type;

    typedef struct packed {
        mode_type                        mode;
        logic [CNT_W-1:0]                count;
        logic [rpm_pkg::PMC_FLAG_W-1:0]  flags;
        logic                            idle_req;
        logic                            stop_req;
        logic                            mon_enable;
        logic                            mon_level;
        logic                            mon_select;
        logic                            poweron_flag;
        rpm_pkg::apb_rsp_type            rsp;
        logic                            pin_oe;
        logic                            core_reset;
        logic                            cpu_clk_en;
        logic                            osc_enable;
        logic                            watchdog_enable;
        logic                            fetch_start;
    } state_type;

    state_type st;
    state_type next_st;

    logic       supply_above;
    logic       regulator_low;

    level_sync #(
        .WIDTH   (2)
    ) pin_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .async_in({supply_above_pin, regulator_low_pin}),
        .sync_out({supply_above, regulator_low})
    );

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [7:0] reg_index(
        input logic [rpm_pkg::ADDR_W-1:0] addr
    );
        reg_index = addr[9:2];
    endfunction

    function automatic logic reg_hit(input logic [rpm_pkg::ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx     = reg_index(addr);
        reg_hit = (addr[1:0] == 2'h0) && (addr[11:10] == 2'h0) &&
                  (idx == rpm_pkg::PMC_INDEX || idx == rpm_pkg::SMC_INDEX ||
                   idx == rpm_pkg::RSS_INDEX);
    endfunction

    // Register reset on any reset entry; monitor state survives
    function automatic state_type enter_reset(
        input state_type s,
        input mode_type  m,
        input logic      keep_por
    );
        state_type r;
        r              = s;
        r.mode         = m;
        r.count        = HOLD_LOAD;
        r.flags        = rpm_pkg::PMC_RESET[7:2];
        r.idle_req     = 1'b0;
        r.stop_req     = 1'b0;
        r.poweron_flag = keep_por & s.poweron_flag;
        enter_reset    = r;
    endfunction

    // Release path shared by monitor, flash and soft resets
    function automatic state_type leave_reset(
        input state_type s,
        input logic      level_high,
        input logic      reg_low
    );
        state_type r;
        r = s;
        if (level_high && reg_low) begin
            r.mode = S_STUCK;
        end else begin
            r.mode        = S_RUN;
            r.fetch_start = 1'b1;
        end
        leave_reset = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state

    logic [7:0] rd_byte;
    logic       setup;
    logic       wr_en;
    logic [7:0] wr_idx;
    logic       mon_trip;
    logic       flash_err;
    logic       soft_req;
    logic [1:0] mode_set;    // Fresh request beats the entry clear

    always_comb begin
        next_st             = st;
        next_st.fetch_start = 1'b0;
        setup  = apb_req.psel && !apb_req.penable;
        wr_idx = reg_index(apb_req.paddr);
        wr_en  = apb_req.psel && apb_req.penable && st.rsp.pready &&
                 apb_req.pwrite && !st.rsp.pslverr;
        soft_req = 1'b0;
        mode_set = apb_req.pwdata[1:0] &
                   {2{wr_en && wr_idx == rpm_pkg::PMC_INDEX}};

        // Bus answers in the cycle after setup
        rd_byte = 8'h00;
        unique case (wr_idx)
            rpm_pkg::PMC_INDEX: rd_byte = {st.flags, 2'b00};
            rpm_pkg::SMC_INDEX: rd_byte = {st.mon_enable,
                                           supply_above,
                                           st.mon_level, 5'h00};
            rpm_pkg::RSS_INDEX: rd_byte = {6'h00, st.poweron_flag, 1'b0};
            default:            rd_byte = 8'h00;
        endcase
        next_st.rsp.pready  = setup;
        next_st.rsp.pslverr = setup && !reg_hit(apb_req.paddr);
        next_st.rsp.prdata  = (setup && reg_hit(apb_req.paddr) &&
                               !apb_req.pwrite) ? {24'h000000, rd_byte}
                                                : 32'h00000000;

        if (wr_en) begin
            unique case (wr_idx)
                rpm_pkg::PMC_INDEX: begin
                    next_st.flags = apb_req.pwdata[7:2];
                    next_st.stop_req |= mode_set[rpm_pkg::PMC_STOP_BIT];
                    next_st.idle_req |= mode_set[rpm_pkg::PMC_IDLE_BIT];
                end
                rpm_pkg::SMC_INDEX: begin
                    next_st.mon_enable = apb_req.pwdata[rpm_pkg::SMC_EN_BIT];
                    next_st.mon_level  = apb_req.pwdata[rpm_pkg::SMC_LVL_BIT];
                end
                rpm_pkg::RSS_INDEX: begin
                    // Selecting early may trip at once
                    next_st.mon_select = apb_req.pwdata[rpm_pkg::RSS_POR_BIT];
                    soft_req = apb_req.pwdata[rpm_pkg::RSS_SOFT_BIT];
                end
                default: begin
                end
            endcase
        end

        mon_trip  = st.mon_enable && st.mon_select && !supply_above;
        flash_err = flash_write_attempt &&
                    !(st.mon_enable && st.mon_level);

        unique case (st.mode)
            S_POR_WAIT: begin
                if (supply_above) begin
                    next_st.mode  = S_POR_DELAY;
                    next_st.count = POR_LOAD;
                end
            end
            S_POR_DELAY: begin
                if (!supply_above) begin
                    next_st.mode = S_POR_WAIT;
                end else if (st.count == '0) begin
                    next_st.mode         = S_RUN;
                    next_st.poweron_flag = 1'b1;
                    next_st.fetch_start  = 1'b1;
                end else begin
                    next_st.count = st.count - 1'b1;
                end
            end
            S_RUN, S_IDLE, S_STOP: begin
                if (mon_trip) begin
                    next_st = enter_reset(next_st, S_MON_HOLD, 1'b0);
                end else if (flash_err || soft_req) begin
                    next_st = enter_reset(next_st, S_SOFT_HOLD, 1'b0);
                end else if (st.mode == S_RUN && instr_done &&
                             st.stop_req) begin
                    next_st.mode     = S_STOP;
                    next_st.stop_req = mode_set[rpm_pkg::PMC_STOP_BIT];
                    next_st.idle_req = mode_set[rpm_pkg::PMC_IDLE_BIT];
                end else if (st.mode == S_RUN && instr_done &&
                             st.idle_req) begin
                    next_st.mode     = S_IDLE;
                    next_st.idle_req = mode_set[rpm_pkg::PMC_IDLE_BIT];
                end else if (st.mode == S_IDLE && irq_pending) begin
                    next_st.mode = S_RUN;
                end
            end
            S_MON_HOLD: begin
                // No power-on delay on this path
                if (supply_above) begin
                    next_st = leave_reset(next_st, st.mon_level,
                                          regulator_low);
                end
            end
            S_SOFT_HOLD: begin
                if (st.count == '0) begin
                    next_st = leave_reset(next_st,
                                          st.mon_enable && st.mon_level,
                                          regulator_low);
                end else begin
                    next_st.count = st.count - 1'b1;
                end
            end
            S_STUCK: begin
                // Only a power-on reset clears this
                next_st.mode = S_STUCK;
            end
        endcase

        // Registered outputs follow the next mode
        next_st.core_reset = !(next_st.mode inside {S_RUN, S_IDLE, S_STOP});
        next_st.pin_oe     = next_st.mode inside
                             {S_POR_WAIT, S_POR_DELAY, S_MON_HOLD,
                              S_STUCK};
        next_st.cpu_clk_en = next_st.mode == S_RUN;
        next_st.osc_enable = next_st.mode != S_STOP;
        next_st.watchdog_enable = !next_st.core_reset &&
                                  next_st.mode != S_STOP;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st              <= '0;
            st.mode         <= S_POR_WAIT;
            st.mon_enable   <= 1'b1;
            st.mon_level    <= 1'b0;
            st.mon_select   <= 1'b1;
            st.pin_oe       <= 1'b1;
            st.core_reset   <= 1'b1;
            st.osc_enable   <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, straight from the state register or tied to constants

    assign apb_rsp            = st.rsp;
    assign reset_pin_o        = 1'b0;
    assign reset_pin_oe       = st.pin_oe;
    // Core reset also resets the stack pointer; data memory is untouched
    assign core_reset         = st.core_reset;
    assign port_latch_force   = st.core_reset;
    assign port_latch_value   = rpm_pkg::PORT_LATCH_RESET;
    assign weak_pullup_en     = 1'b1;
    assign cpu_clk_en         = st.cpu_clk_en;
    assign osc_enable         = st.osc_enable;
    assign clock_internal_sel = 1'b1;
    assign watchdog_enable    = st.watchdog_enable;
    assign watchdog_div       = rpm_pkg::WATCHDOG_DIV;
    assign fetch_start        = st.fetch_start;
    assign fetch_address      = rpm_pkg::BOOT_ADDRESS;

endmodule

/* pkg/rpm_pkg.sv */
// Constants, register map and bus carrier types for the reset and power
// mode controller. Assumes a 200 MHz APB clock and 32-bit APB data.
package rpm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned POR_DELAY_NS  = 1000;
    localparam int unsigned HOLD_CYCLES   = 4;
    localparam int unsigned CNT_W         = 16;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam int unsigned ADDR_W       = 12;
    localparam logic [7:0]  PMC_INDEX    = 8'h87;
    localparam logic [7:0]  SMC_INDEX    = 8'hFF;
    localparam logic [7:0]  RSS_INDEX    = 8'hEF;

    // Power mode control fields
    localparam int unsigned PMC_FLAG_LSB = 2;
    localparam int unsigned PMC_FLAG_W   = 6;
    localparam int unsigned PMC_STOP_BIT = 1;
    localparam int unsigned PMC_IDLE_BIT = 0;
    localparam logic [7:0]  PMC_RESET    = 8'h00;

    // Supply monitor control fields
    localparam int unsigned SMC_EN_BIT   = 7;
    localparam int unsigned SMC_STAT_BIT = 6;
    localparam int unsigned SMC_LVL_BIT  = 5;

    // Reset source fields
    localparam int unsigned RSS_POR_BIT  = 1;
    localparam int unsigned RSS_SOFT_BIT = 4;

    ////////////////////////////////////////////////////////////////////////
    // Values presented to the rest of the chip
    localparam logic [7:0]  PORT_LATCH_RESET = 8'hFF;
    localparam logic [15:0] BOOT_ADDRESS     = 16'h0000;
    localparam logic [3:0]  WATCHDOG_DIV     = 4'hC;

    ////////////////////////////////////////////////////////////////////////
    // Bus carriers
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_type;

endpackage

/* core/level_sync.sv */
// Two-flop synchroniser for asynchronous level inputs.
// Assumes the inputs are slow levels; no pulse is guaranteed to survive.
`timescale 1ns/1ps
module level_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    initial begin
        if (WIDTH < 1) begin
            $error("level_sync: WIDTH must be at least 1");
        end
    end

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

/* sim/supply_model.sv */
// Model of the supply monitor comparator and the uncalibrated regulator.
// Assumes the bench commands the analog levels; outputs are async levels.
`timescale 1ns/1ps
module supply_model (
    input  wire logic supply_ok,
    input  wire logic reg_low,
    output logic      supply_above_pin,
    output logic      regulator_low_pin
);
    // Odd lags keep the level changes off the pclk edges
    assign #1.3 supply_above_pin = supply_ok;
    assign #0.7 regulator_low_pin = reg_low;
endmodule

/* sim/rpm_chk.sv */
// Port checker for reset_power_control.
// Assumes a bind to the design; single pclk domain, presetn reset.
`timescale 1ns/1ps
module rpm_chk (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire rpm_pkg::apb_req_type apb_req,
    input wire rpm_pkg::apb_rsp_type apb_rsp,
    input wire logic                 flash_write_attempt,
    input wire logic                 irq_pending,
    input wire logic                 instr_done,
    input wire logic                 reset_pin_o,
    input wire logic                 reset_pin_oe,
    input wire logic                 core_reset,
    input wire logic                 port_latch_force,
    input wire logic [7:0]           port_latch_value,
    input wire logic                 cpu_clk_en,
    input wire logic                 osc_enable,
    input wire logic                 watchdog_enable,
    input wire logic                 fetch_start,
    input wire logic [15:0]          fetch_address
);
    logic en_q;
    logic lvl_q;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Shadow of monitor enable and level; only power-on reset restores it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q  <= 1'b1;
            lvl_q <= 1'b0;
        end else if (apb_req.psel && apb_req.penable && apb_rsp.pready &&
                     apb_req.pwrite && apb_req.paddr == 12'h3FC) begin
            en_q  <= apb_req.pwdata[7];
            lvl_q <= apb_req.pwdata[5];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_setup_answer: assert property (
        apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
        else $error("no answer after setup");
    a_ready_pulse: assert property (
        apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready longer than one cycle");
    a_mode_bits_zero: assert property (
        apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == 12'h21C
        |-> apb_rsp.prdata[1:0] == 2'h0)
        else $error("mode select bits read back");
    a_pin_low: assert property (
        reset_pin_oe |-> !reset_pin_o && core_reset)
        else $error("reset pin driven wrongly");
    a_latch_force: assert property (
        core_reset |-> port_latch_force && port_latch_value == 8'hFF)
        else $error("port latches not forced");
    a_core_halt: assert property (
        core_reset |-> !cpu_clk_en && !watchdog_enable)
        else $error("core runs in reset");
    a_fetch_start: assert property (
        $fell(core_reset) |-> fetch_start && fetch_address == 16'h0000
        ##1 !fetch_start)
        else $error("no single fetch pulse on release");
    a_idle_wake: assert property (
        !cpu_clk_en && osc_enable && !core_reset && irq_pending
        |=> cpu_clk_en)
        else $error("idle not left on interrupt");
    a_mode_after_instr: assert property (
        $fell(cpu_clk_en) |-> $past(instr_done) || core_reset)
        else $error("clock gated before instruction end");
    a_stop_entry: assert property (
        $fell(osc_enable) |-> $past(instr_done) && !cpu_clk_en)
        else $error("bad stop entry");
    a_flash_err: assert property (
        flash_write_attempt && !core_reset && !(en_q && lvl_q)
        |-> ##[1:2] core_reset)
        else $error("unprotected flash write kept running");
endmodule

/* sim/testbench.sv */
// Self-checking bench for reset_power_control over APB.
// Assumes the bench commands the analog levels and the supply model drives the pins; one 200 MHz clock.
`timescale 1ns/1ps
module testbench;
    localparam int POR_NS = 50;
    localparam int POR_CYC = POR_NS / 5;
    logic pclk, presetn, supply_ok, reg_low, flash_write_attempt;
    logic irq_pending, instr_done, supply_above_pin, regulator_low_pin;
    logic reset_pin_o, reset_pin_oe, core_reset, port_latch_force;
    logic weak_pullup_en, cpu_clk_en, osc_enable, clock_internal_sel;
    logic watchdog_enable, fetch_start;
    logic [7:0] port_latch_value;
    logic [3:0] watchdog_div;
    logic [15:0] fetch_address;
    rpm_pkg::apb_req_type apb_req;
    rpm_pkg::apb_rsp_type apb_rsp;
    int failures, tests_run;

    reset_power_control #(.POR_DELAY_NS(POR_NS), .HOLD_CYCLES(4))
    u_reset_power_control (.pclk(pclk), .presetn(presetn),
        .apb_req(apb_req), .apb_rsp(apb_rsp),
        .supply_above_pin(supply_above_pin),
        .regulator_low_pin(regulator_low_pin),
        .flash_write_attempt(flash_write_attempt),
        .irq_pending(irq_pending), .instr_done(instr_done),
        .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe),
        .core_reset(core_reset), .port_latch_force(port_latch_force),
        .port_latch_value(port_latch_value),
        .weak_pullup_en(weak_pullup_en), .cpu_clk_en(cpu_clk_en),
        .osc_enable(osc_enable), .clock_internal_sel(clock_internal_sel),
        .watchdog_enable(watchdog_enable), .watchdog_div(watchdog_div),
        .fetch_start(fetch_start), .fetch_address(fetch_address));
    supply_model u_supply_model (.supply_ok(supply_ok), .reg_low(reg_low),
        .supply_above_pin(supply_above_pin),
        .regulator_low_pin(regulator_low_pin));

    always #2.5 pclk = ~pclk;

    task final_report;
        if (failures == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // One APB transfer; an idle cycle first so no signal is set twice
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d,
             output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        apb_req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        r = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        if (apb_rsp.pready !== 1'b1) begin
            failures++;
            final_report;
        end
    endtask

    task wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        chk(r & {24'hFFFFFF, m}, {24'h0, x});
    endtask

    task pulse(input logic flash);
        @(posedge pclk);
        if (flash)
            flash_write_attempt <= 1'b1;
        else
            instr_done <= 1'b1;
        @(posedge pclk);
        flash_write_attempt <= 1'b0;
        instr_done <= 1'b0;
    endtask

    task wait_rst(input logic v, output int n);
        n = 0;
        while (core_reset !== v && n < 400) begin
            @(posedge pclk);
            n++;
        end
        if (core_reset !== v) begin
            failures++;
            final_report;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task t_por;
        int n;
        logic [31:0] r;
        logic e;
        chk({reset_pin_oe, core_reset, port_latch_force, weak_pullup_en},
            32'hF);
        presetn <= 1'b1;
        wait_rst(1'b0, n);
        chk(32'(n >= POR_CYC), 32'h1);
        chk({fetch_address, watchdog_div, port_latch_value,
             clock_internal_sel}, {16'h0000, 4'hC, 8'hFF, 1'b1});
        rd(12'h3BC, 8'h02, 8'h02);
        rd(12'h3FC, 8'hFF, 8'hC0);
        rd(12'h21C, 8'hFF, 8'h00);
        apb(1'b0, 12'h000, 8'h00, r, e);
        chk(e, 32'h1);
        wr(12'h21C, 8'hFC);
        rd(12'h21C, 8'hFF, 8'hFC);
        chk(watchdog_enable, 32'h1);
    endtask

    task t_idle;
        wr(12'h21C, 8'hFD);
        rd(12'h21C, 8'hFF, 8'hFC);
        chk(cpu_clk_en, 32'h1);
        pulse(1'b0);
        @(posedge pclk);
        chk({cpu_clk_en, osc_enable, watchdog_enable}, 32'h3);
        irq_pending <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(cpu_clk_en, 32'h1);
        irq_pending <= 1'b0;
        rd(12'h21C, 8'hFF, 8'hFC);
    endtask

    task t_stop;
        int n;
        wr(12'h3FC, 8'h00);
        wr(12'h21C, 8'hFE);
        pulse(1'b0);
        @(posedge pclk);
        chk({cpu_clk_en, osc_enable}, 32'h0);
        irq_pending <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(osc_enable, 32'h0);
        irq_pending <= 1'b0;
        wr(12'h3BC, 8'h12);
        @(posedge pclk);
        chk({core_reset, reset_pin_oe}, 32'h2);
        wait_rst(1'b0, n);
        chk(osc_enable, 32'h1);
        rd(12'h21C, 8'hFF, 8'h00);
        rd(12'h3BC, 8'h02, 8'h00);
        rd(12'h3FC, 8'hFF, 8'h40);
    endtask

    task t_flash;
        int n;
        pulse(1'b1);
        wait_rst(1'b1, n);
        chk(32'(n <= 3), 32'h1);
        wait_rst(1'b0, n);
        wr(12'h3FC, 8'hA0);
        pulse(1'b1);
        repeat (3) @(posedge pclk);
        chk(core_reset, 32'h0);
        wr(12'h3FC, 8'h80);
    endtask

    task t_mon;
        int n;
        wr(12'h3BC, 8'h02);
        supply_ok <= 1'b0;
        wait_rst(1'b1, n);
        @(posedge pclk);
        chk(reset_pin_oe, 32'h1);
        rd(12'h3FC, 8'hFF, 8'h80);
        supply_ok <= 1'b1;
        wait_rst(1'b0, n);
        chk(32'(n < POR_CYC), 32'h1);
        rd(12'h3BC, 8'h02, 8'h00);
    endtask

    task t_stuck;
        int n;
        wr(12'h3FC, 8'hA0);
        reg_low <= 1'b1;
        wr(12'h3BC, 8'h12);
        repeat (30) @(posedge pclk);
        chk({core_reset, reset_pin_oe}, 32'h3);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        reg_low <= 1'b0;
        wait_rst(1'b0, n);
        rd(12'h3FC, 8'hFF, 8'hC0);
        rd(12'h3BC, 8'h02, 8'h02);
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        supply_ok = 1'b1;
        reg_low = 1'b0;
        flash_write_attempt = 1'b0;
        irq_pending = 1'b0;
        instr_done = 1'b0;
        apb_req = '0;
        failures = 0;
        tests_run = 0;
        repeat (10) @(posedge pclk);
        t_por;
        t_idle;
        t_stop;
        t_flash;
        t_mon;
        t_stuck;
        final_report;
    end
endmodule

bind reset_power_control rpm_chk u_rpm_chk (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp),
    .flash_write_attempt(flash_write_attempt), .irq_pending(irq_pending),
    .instr_done(instr_done), .reset_pin_o(reset_pin_o),
    .reset_pin_oe(reset_pin_oe), .core_reset(core_reset),
    .port_latch_force(port_latch_force),
    .port_latch_value(port_latch_value), .cpu_clk_en(cpu_clk_en),
    .osc_enable(osc_enable), .watchdog_enable(watchdog_enable),
    .fetch_start(fetch_start), .fetch_address(fetch_address));
